// *** zxd_ctrl.sv ***
// Zero-cross detector control: APB registers, level, pin output, edge interrupt
// How it works
// - Normal polarity: sinking reads 1, sourcing 0.
// - Inverted polarity: sourcing reads 1, sinking 0.
// - Polarity inverts level for status, pin, edges.
// - Output enable drives level onto pin.
// - Enabled rising/falling edges set the flag.
// - Control bits 3 and 2 read zero.
// - Level read-only; others reset 0; enable from fuse.
// - Flag and its enable at bit 4.
// - Fuse is bit 7 of config low byte.
// - Fuse 0 enables at power-on; 1 disables.
// - Polarity change makes an edge, enable regardless.
// - Software clears flag; simultaneous edge keeps it.
`timescale 1ns/10ps
`include "zxd_regs.svh"
module zxd_ctrl #(
	parameter int ADDR_W = 8,
	parameter int SYNC_STAGES = `ZXD_SYNC_STAGES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] config_word_2,
	input wire logic crossing_sink_active,
	output logic analog_enable,
	output logic crossing_out,
	output logic crossing_out_oe,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Register state

	zxd_pkg::zxd_init_t init_state;
	logic en_reg;
	logic oe_reg;
	logic pol_reg;
	logic intp_reg;
	logic intn_reg;
	logic irq_en_reg;
	logic flag_reg;
	logic flag_next;
	logic [31:0] prdata_reg;

	////////////////////////////////////////////////////////////////////////////////
	// APB decode

	logic setup_phase;
	logic access_phase;
	logic wr_access;
	logic [7:0] word_addr;
	logic hit_ctrl;
	logic hit_irq_en;
	logic hit_irq_req;
	logic hit_any;
	logic wr_ctrl;
	logic wr_irq_en;
	logic wr_irq_req;
	logic flag_clear;

	// Zero-wait slave: every access completes in its first access cycle
	assign setup_phase = psel & ~penable;
	assign access_phase = psel & penable;
	assign wr_access = access_phase & pwrite;
	assign word_addr = 8'(paddr) & 8'hFC;
	assign hit_ctrl = (word_addr == `ZXD_OFF_CTRL);
	assign hit_irq_en = (word_addr == `ZXD_OFF_IRQ_EN);
	assign hit_irq_req = (word_addr == `ZXD_OFF_IRQ_REQ);
	assign hit_any = hit_ctrl | hit_irq_en | hit_irq_req;
	assign wr_ctrl = wr_access & hit_ctrl;
	assign wr_irq_en = wr_access & hit_irq_en;
	assign wr_irq_req = wr_access & hit_irq_req;
	assign flag_clear = wr_irq_req & pwdata[`ZXD_BIT_IRQ];
	assign pready = 1'b1;
	assign pslverr = access_phase & ~hit_any; // Unmapped word answers with an error

	////////////////////////////////////////////////////////////////////////////////
	// Analog indication and crossing level

	logic sink_sync;
	logic raw_level;
	logic level_next;
	logic level_reg;
	logic rise;
	logic fall;

	// Analog stage is asynchronous to pclk
	zxd_sync #(
		.STAGES(SYNC_STAGES)
	) u_sink_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(crossing_sink_active),
		.q(sink_sync)
	);

	// Disabled front end neither sinks nor sources; treated as not sinking
	assign raw_level = en_reg & sink_sync;
	// Polarity applied before status, pin and edges
	assign level_next = raw_level ^ pol_reg;

	// Edges seen on the adjusted level, so a polarity write is an edge too
	zxd_edge u_edge (
		.pclk(pclk),
		.presetn(presetn),
		.level_in(level_next),
		.level_q(level_reg),
		.rise(rise),
		.fall(fall)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Power-on enable from the configuration fuse

	// Fuse is sampled after reset release, never inside the async reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_state <= zxd_pkg::ZXD_LOAD;
		end else begin
			case (init_state)
				zxd_pkg::ZXD_LOAD: init_state <= zxd_pkg::ZXD_RUN;
				zxd_pkg::ZXD_RUN: init_state <= zxd_pkg::ZXD_RUN;
				default: init_state <= zxd_pkg::ZXD_LOAD;
			endcase
		end
	end

	logic fuse_off;
	assign fuse_off = config_word_2[`ZXD_BIT_FUSE];

	// Fuse clear means active at power-on; set means software must enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_reg <= 1'b0;
		end else if (init_state == zxd_pkg::ZXD_LOAD) begin
			en_reg <= ~fuse_off;
		end else if (wr_ctrl) begin
			en_reg <= pwdata[`ZXD_BIT_EN];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control and enable registers

	// Bits 3:2 and the level bit have no storage, writes there vanish
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oe_reg <= `ZXD_RST_OE;
			pol_reg <= `ZXD_RST_POL;
			intp_reg <= `ZXD_RST_INTP;
			intn_reg <= `ZXD_RST_INTN;
		end else if (wr_ctrl) begin
			oe_reg <= pwdata[`ZXD_BIT_OE];
			pol_reg <= pwdata[`ZXD_BIT_POL];
			intp_reg <= pwdata[`ZXD_BIT_INTP];
			intn_reg <= pwdata[`ZXD_BIT_INTN];
		end
	end

	// Interrupt enable, bit 4 of its own register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en_reg <= `ZXD_RST_IRQ_EN;
		end else if (wr_irq_en) begin
			irq_en_reg <= pwdata[`ZXD_BIT_IRQ];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sticky flag

	logic edge_hit;
	// An enabled edge in a clearing cycle must not be lost, so set wins
	assign edge_hit = (rise & intp_reg) | (fall & intn_reg);
	assign flag_next = edge_hit | (flag_reg & ~flag_clear);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_reg <= `ZXD_RST_IRQ_FLAG;
		end else begin
			flag_reg <= flag_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data

	zxd_pkg::zxd_byte_t ctrl_view;
	zxd_pkg::zxd_byte_t irq_en_view;
	zxd_pkg::zxd_byte_t irq_req_view;
	zxd_pkg::zxd_byte_t rd_byte;

	// Unused bits are tied low in the views
	assign ctrl_view = {en_reg, oe_reg, level_reg, pol_reg, 2'b00, intp_reg, intn_reg};
	assign irq_en_view = {3'b000, irq_en_reg, 4'h0};
	assign irq_req_view = {3'b000, flag_reg, 4'h0};
	assign rd_byte = hit_ctrl ? ctrl_view :
		hit_irq_en ? irq_en_view :
		hit_irq_req ? irq_req_view : 8'h00;

	// Captured in setup so data stands through the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h00000000;
		end else if (setup_phase & ~pwrite) begin
			prdata_reg <= {24'h000000, rd_byte};
		end
	end

	assign prdata = prdata_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign analog_enable = en_reg;
	assign crossing_out = level_reg;
	assign crossing_out_oe = oe_reg;
	assign irq = flag_reg & irq_en_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Cycles since reset release, saturating, for history-based checks
	logic [1:0] age_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			age_reg <= 2'h0;
		end else if (age_reg != 2'h3) begin
			age_reg <= age_reg + 2'h1;
		end
	end

	a_sink_normal_pol: assert property (
		(en_reg && !pol_reg && sink_sync && !wr_ctrl) |=> level_reg
	) else $error("sink with normal polarity did not read one");

	a_source_inverted_pol: assert property (
		(en_reg && pol_reg && !sink_sync && !wr_ctrl) |=> level_reg
	) else $error("source with inverted polarity did not read one");

	a_status_tracks_level: assert property (
		(setup_phase && !pwrite && hit_ctrl) |=> prdata[5] == $past(level_reg)
	) else $error("status bit differs from adjusted level");

	a_pin_output_drive: assert property (
		wr_ctrl |=> crossing_out_oe == $past(pwdata[`ZXD_BIT_OE])
	) else $error("pin output enable does not follow the written bit");

	a_rise_sets_flag: assert property (
		(rise && intp_reg) |=> flag_reg
	) else $error("enabled rising edge did not set flag");

	a_fall_sets_flag: assert property (
		(fall && intn_reg) |=> flag_reg
	) else $error("enabled falling edge did not set flag");

	a_flag_unchanged: assert property (
		(!flag_reg && !(rise && intp_reg) && !(fall && intn_reg)) |=> !flag_reg
	) else $error("flag set without an enabled edge");

	a_unimpl_bits_zero: assert property (
		(setup_phase && !pwrite && hit_ctrl) |=> prdata[3:2] == 2'b00
	) else $error("unimplemented control bits read nonzero");

	a_fuse_loads_enable: assert property (
		(init_state == zxd_pkg::ZXD_LOAD) |=> en_reg == !$past(config_word_2[7])
	) else $error("enable not loaded from fuse");

	a_irq_bit_four: assert property (
		(setup_phase && !pwrite && hit_irq_req) |=> prdata[4] == $past(flag_reg)
	) else $error("flag not at bit four");

	a_pol_change_edge: assert property (
		($changed(pol_reg) && $stable(raw_level) && intp_reg && intn_reg
			&& age_reg == 2'h3) |-> flag_next
	) else $error("polarity change produced no interrupt");

	a_set_beats_clear: assert property (
		(flag_clear && edge_hit) |=> flag_reg ##1 (flag_reg || flag_clear || $past(flag_clear))
	) else $error("edge lost during clear");

	a_clear_works: assert property (
		(flag_clear && !edge_hit) |=> !flag_reg
	) else $error("clear did not clear the flag");

	a_sync_two_stages: assert property (
		(age_reg == 2'h3) |-> sink_sync == $past(crossing_sink_active, 2)
	) else $error("sink indication not delayed by two stages");

	a_irq_output: assert property (
		irq == (flag_reg && irq_en_reg)
	) else $error("interrupt output disagrees with flag and mask");

	a_pin_level_follows: assert property (
		(age_reg != 2'h0) |-> crossing_out == $past(level_next)
	) else $error("pin level does not follow the adjusted level");

	a_sink_low_normal: assert property (
		(en_reg && !pol_reg && !sink_sync) |=> !level_reg
	) else $error("source with normal polarity did not read zero");

	a_sink_low_inverted: assert property (
		(en_reg && pol_reg && sink_sync) |=> !level_reg
	) else $error("sink with inverted polarity did not read zero");

	a_ctrl_fields_write: assert property (
		wr_ctrl |=> {oe_reg, pol_reg, intp_reg, intn_reg} == {$past(pwdata[`ZXD_BIT_OE]),
			$past(pwdata[`ZXD_BIT_POL]), $past(pwdata[`ZXD_BIT_INTP]), $past(pwdata[`ZXD_BIT_INTN])}
	) else $error("control fields do not hold the written value");

	a_enable_write: assert property (
		(wr_ctrl && init_state == zxd_pkg::ZXD_RUN) |=> en_reg == $past(pwdata[`ZXD_BIT_EN])
	) else $error("enable does not hold the written value");

	a_enable_held: assert property (
		(init_state == zxd_pkg::ZXD_RUN && !wr_ctrl) |=> $stable(en_reg)
	) else $error("enable changed without a write");

	a_irq_en_write: assert property (
		wr_irq_en |=> irq_en_reg == $past(pwdata[`ZXD_BIT_IRQ])
	) else $error("interrupt enable does not hold the written value");

	a_rise_one_cycle: assert property (
		rise |=> !rise
	) else $error("rising edge seen on two cycles in a row");

	a_fall_one_cycle: assert property (
		fall |=> !fall
	) else $error("falling edge seen on two cycles in a row");

endmodule // zxd_ctrl

// *** zxd_regs.svh ***
// Register offsets, field positions, reset values and timing counts for the crossing block
`ifndef ZXD_REGS_SVH
`define ZXD_REGS_SVH

`define ZXD_OFF_CTRL 8'h00
`define ZXD_OFF_IRQ_EN 8'h04
`define ZXD_OFF_IRQ_REQ 8'h08

`define ZXD_BIT_EN 7
`define ZXD_BIT_OE 6
`define ZXD_BIT_LEVEL 5
`define ZXD_BIT_POL 4
`define ZXD_BIT_INTP 1
`define ZXD_BIT_INTN 0
`define ZXD_BIT_IRQ 4
`define ZXD_BIT_FUSE 7

`define ZXD_RST_OE 1'b0
`define ZXD_RST_POL 1'b0
`define ZXD_RST_INTP 1'b0
`define ZXD_RST_INTN 1'b0
`define ZXD_RST_IRQ_EN 1'b0
`define ZXD_RST_IRQ_FLAG 1'b0
`define ZXD_RST_LEVEL 1'b0

`define ZXD_SYNC_STAGES 2

`endif

// *** zxd_pkg.sv ***
// Types shared by the crossing block files
package zxd_pkg;

	// Power-on load of the enable from the fuse, then normal running
	typedef enum logic {
		ZXD_LOAD,
		ZXD_RUN
	} zxd_init_t;

	typedef logic [7:0] zxd_byte_t;

endpackage

// *** zxd_sync.sv ***
// Multi-stage synchroniser for an asynchronous level
`timescale 1ns/10ps
module zxd_sync #(
	parameter int STAGES = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic d,
	output logic q
);

	logic [STAGES-1:0] chain_reg;

	// Only the last stage is visible; earlier stages may be metastable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chain_reg <= '0;
		end else begin
			chain_reg <= {chain_reg[STAGES-2:0], d};
		end
	end

	assign q = chain_reg[STAGES-1];

endmodule // zxd_sync

// *** zxd_edge.sv ***
// Rising and falling edge detector on a same-clock level
`timescale 1ns/10ps
`include "zxd_regs.svh"
module zxd_edge (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic level_in,
	output logic level_q,
	output logic rise,
	output logic fall
);

	logic level_reg;

	// Previous level, compared with the new one in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_reg <= `ZXD_RST_LEVEL;
		end else begin
			level_reg <= level_in;
		end
	end

	assign level_q = level_reg;
	assign rise = level_in & ~level_reg;
	assign fall = ~level_in & level_reg;

endmodule // zxd_edge

// *** zxd_analog_model.sv ***
// Behavioural sense stage that reports sinking or sourcing to the crossing block
`timescale 1ns/10ps
module zxd_analog_model (
	input wire logic analog_enable,
	input wire logic sink_req,
	output logic crossing_sink_active
);
	// Unpowered stage neither sinks nor sources, so it reads as not sinking
	// Small delay keeps the indication off the clock edge, like a real comparator
	assign #3 crossing_sink_active = analog_enable & sink_req;
endmodule // zxd_analog_model

// *** zero_cross_detect_control_tb_top.sv ***
// Self-checking bench for the crossing control block
`timescale 1ns/10ps
`include "zxd_regs.svh"
module zero_cross_detect_control_tb_top;
	typedef struct packed {logic [31:0] data; logic err;} zxd_exp_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sink_req, sink_act;
	logic analog_enable, crossing_out, crossing_out_oe, irq;
	logic [7:0] paddr, config_word_2;
	logic [31:0] pwdata, prdata;
	zxd_exp_t exp_q[$];
	zxd_exp_t e;
	int err_total = 0, tests_run = 0, cyc = 0, i;
	logic p, ip, inn, s, s0, l0, l1, f;
	////////////////////////////////////////////////////////////////////////////
	zxd_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .config_word_2(config_word_2), .crossing_sink_active(sink_act),
		.analog_enable(analog_enable), .crossing_out(crossing_out),
		.crossing_out_oe(crossing_out_oe), .irq(irq));
	zxd_analog_model model_u (.analog_enable(analog_enable), .sink_req(sink_req),
		.crossing_sink_active(sink_act));
	// Clock and timeout guard
	initial begin
		pclk = 0;
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			err_total++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] expd);
		tests_run++;
		if (seen !== expd) begin
			err_total++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, expd);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Bus master: holds the request until pready is seen at a rising edge
	task automatic apb_go(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask
	task automatic apb_rd(input logic [7:0] a, input logic [7:0] d, input logic err);
		exp_q.push_back('{{24'h000000, d}, err});
		apb_go(0, a, 32'h00000000);
	endtask
	// Read monitor: oldest note is matched against each completed read
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			check(prdata, e.data);
			check({31'h0, pslverr}, {31'h0, e.err});
		end
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		{psel, penable, pwrite, sink_req} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		config_word_2 = 8'h00;
		presetn = 0;
		s = $urandom(75152);
		repeat (2) @(posedge pclk);
		presetn <= 1;
		repeat (2) @(posedge pclk);
		// Power-on values with the fuse clear
		apb_rd(`ZXD_OFF_CTRL, 8'h80, 0);
		apb_rd(`ZXD_OFF_IRQ_EN, 8'h00, 0);
		apb_rd(`ZXD_OFF_IRQ_REQ, 8'h00, 0);
		apb_rd(8'h0C, 8'h00, 1);
		@(negedge pclk);
		check({31'h0, analog_enable}, 32'h1);
		check({30'h0, crossing_out_oe, irq}, 32'h0);
		$display("test reset done");
		// All ones: bits 3..2 stay zero, polarity flip alone raises the flag
		apb_go(1, `ZXD_OFF_CTRL, 32'hFFFFFFFF);
		repeat (4) @(posedge pclk);
		apb_rd(`ZXD_OFF_CTRL, 8'hF3, 0);
		@(negedge pclk);
		check({30'h0, crossing_out, crossing_out_oe}, 32'h3);
		apb_rd(`ZXD_OFF_IRQ_REQ, 8'h10, 0);
		apb_go(1, `ZXD_OFF_IRQ_EN, 32'h00000010);
		apb_go(1, 8'h0C, 32'h000000FF);
		apb_rd(`ZXD_OFF_IRQ_EN, 8'h10, 0);
		$display("test fields done");
		// Random polarity, edge enables and sense changes
		s0 = 0;
		for (i = 0; i < 12; i++) begin
			{p, ip, inn, s} = 4'($urandom);
			apb_go(1, `ZXD_OFF_CTRL, {24'h0, 1'b1, 1'b1, 1'b0, p, 2'b00, ip, inn});
			repeat (5) @(posedge pclk);
			apb_go(1, `ZXD_OFF_IRQ_REQ, 32'h00000010);
			l0 = s0 ^ p;
			sink_req <= s;
			repeat (5) @(posedge pclk);
			l1 = s ^ p;
			f = (l1 & ~l0 & ip) | (~l1 & l0 & inn);
			apb_rd(`ZXD_OFF_CTRL, {2'b11, l1, p, 2'b00, ip, inn}, 0);
			apb_rd(`ZXD_OFF_IRQ_REQ, {3'b000, f, 4'h0}, 0);
			@(negedge pclk);
			check({30'h0, crossing_out, irq}, {30'h0, l1, f});
			s0 = s;
		end
		$display("test edges done");
		// Clearing write lands on the same edge as a new rising edge
		apb_go(1, `ZXD_OFF_CTRL, 32'h000000C2);
		sink_req <= 0;
		repeat (6) @(posedge pclk);
		apb_go(1, `ZXD_OFF_IRQ_REQ, 32'h00000010);
		@(posedge pclk);
		sink_req <= 1;
		apb_go(1, `ZXD_OFF_IRQ_REQ, 32'h00000010);
		apb_rd(`ZXD_OFF_IRQ_REQ, 8'h10, 0);
		$display("test clear race done");
		// Second reset with the fuse set leaves the detector off
		@(posedge pclk);
		presetn <= 0;
		config_word_2 <= 8'h80;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		repeat (2) @(posedge pclk);
		sink_req <= 0;
		apb_rd(`ZXD_OFF_CTRL, 8'h00, 0);
		@(negedge pclk);
		check({31'h0, analog_enable}, 32'h0);
		apb_rd(`ZXD_OFF_IRQ_REQ, 8'h00, 0);
		// Polarity flip with the detector off still flags, mask keeps irq low
		apb_go(1, `ZXD_OFF_CTRL, 32'h00000012);
		repeat (3) @(posedge pclk);
		apb_rd(`ZXD_OFF_CTRL, 8'h32, 0);
		apb_rd(`ZXD_OFF_IRQ_REQ, 8'h10, 0);
		@(negedge pclk);
		check({29'h0, crossing_out, analog_enable, irq}, 32'h4);
		$display("test fuse done");
		repeat (2) @(posedge pclk);
		print_verdict();
	end
endmodule // zero_cross_detect_control_tb_top
